// file: verilog/but_regs.svh
// Register offsets, field positions and reset values of the basic timer
`ifndef BUT_REGS_SVH
`define BUT_REGS_SVH
`define BUT_OFS_CTL0 12'h000
`define BUT_OFS_CTL1 12'h004
`define BUT_OFS_IE 12'h00c
`define BUT_OFS_FLG 12'h010
`define BUT_OFS_SWE 12'h014
`define BUT_OFS_CNT 12'h024
`define BUT_OFS_PRESCALE 12'h028
`define BUT_OFS_CAR 12'h02c
`define BUT_CTL0_RUN 0
`define BUT_CTL0_INHIBIT 1
`define BUT_CTL0_SOURCE 2
`define BUT_CTL0_ONE_SHOT 3
`define BUT_CTL0_RELOAD_BUF 7
`define BUT_CTL1_MMC_LO 4
`define BUT_CTL1_MMC_HI 6
`define BUT_IE_IRQ_EN 0
`define BUT_IE_DMA_EN 8
`define BUT_FLG_UPDATE 0
`define BUT_SWE_FUP 0
`define BUT_RST_BIT 1'b0
`define BUT_RST_CNT 16'h0000
`define BUT_RST_MMC 3'h0
`define BUT_WSTRB_FULL 4'hf
`define BUT_RESP_OKAY 2'h0
`define BUT_RESP_SLVERR 2'h2
`endif

// file: verilog/but_pkg.sv
// Types shared by the basic timer modules
package but_pkg;
  typedef logic [11:0] but_addr_t;
  typedef logic [15:0] but_cnt_t;
  typedef logic [31:0] but_word_t;
  typedef enum logic [2:0] {
    BUT_MMC_RESET = 3'h0,
    BUT_MMC_START = 3'h1,
    BUT_MMC_UPDATE = 3'h2
  } but_mmc_t;
endpackage : but_pkg

// file: verilog/but_prescaler.sv
// Prescaler counter with its shadow divisor
`timescale 1ns/1ps
`include "but_regs.svh"
module but_prescaler
  import but_pkg::*;
(
  input logic clk_i,
  input logic rst_b_i,
  input logic run_i,
  input logic clear_i,
  input logic load_i,
  input but_cnt_t value_i,
  output logic tick_o
);
  but_cnt_t pcnt_r, pcnt_nxt;
  but_cnt_t shadow_r, shadow_nxt;

  always_comb begin
    pcnt_nxt = pcnt_r;
    shadow_nxt = shadow_r;
    if (load_i) begin
      shadow_nxt = value_i;
    end
    if (clear_i) begin
      pcnt_nxt = `BUT_RST_CNT;
    end else if (run_i) begin
      pcnt_nxt = (pcnt_r == shadow_r) ? `BUT_RST_CNT : pcnt_r + 16'h0001;
    end
  end

  // One tick every shadow+1 clocks while running
  assign tick_o = run_i && !clear_i && (pcnt_r == shadow_r);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pcnt_r <= `BUT_RST_CNT;
      shadow_r <= `BUT_RST_CNT;
    end else begin
      pcnt_r <= pcnt_nxt;
      shadow_r <= shadow_nxt;
    end
  end
endmodule : but_prescaler

// file: verilog/but_axil_slave.sv
// AXI4-Lite slave front end for the timer registers
`timescale 1ns/1ps
`include "but_regs.svh"
module but_axil_slave
  import but_pkg::*;
(
  input logic clk_i,
  input logic rst_b_i,
  input logic awvalid_i,
  output logic awready_o,
  input but_addr_t awaddr_i,
  input logic wvalid_i,
  output logic wready_o,
  input but_word_t wdata_i,
  input logic [3:0] wstrb_i,
  output logic bvalid_o,
  input logic bready_i,
  output logic [1:0] bresp_o,
  input logic arvalid_i,
  output logic arready_o,
  output logic rvalid_o,
  input logic rready_i,
  output but_word_t rdata_o,
  output logic [1:0] rresp_o,
  output logic wr_en_o,
  output but_addr_t wr_addr_o,
  output but_word_t wr_data_o,
  input logic wr_err_i,
  input but_word_t rd_data_i,
  input logic rd_err_i
);
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt, fire;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  but_addr_t awaddr_r, awaddr_nxt;
  but_word_t wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic full_word;

  assign fire = aw_full_r && w_full_r && !bvalid_r;
  assign full_word = (wstrb_r == `BUT_WSTRB_FULL);

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid_i && awready_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = awaddr_i;
    end
    if (wvalid_i && wready_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt = wdata_i;
      wstrb_nxt = wstrb_i;
    end
    if (fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      // Partial words are refused, not merged
      bresp_nxt = (wr_err_i || !full_word) ? `BUT_RESP_SLVERR : `BUT_RESP_OKAY;
    end
    if (bvalid_r && bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (arvalid_i && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data_i;
      rresp_nxt = rd_err_i ? `BUT_RESP_SLVERR : `BUT_RESP_OKAY;
    end
    if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `BUT_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `BUT_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;
  assign wr_en_o = fire && full_word;
  assign wr_addr_o = awaddr_r;
  assign wr_data_o = wdata_r;
endmodule : but_axil_slave

// file: verilog/but_timer.sv
// Basic 16-bit up-counting timer with AXI4-Lite registers
`timescale 1ns/1ps
`include "but_regs.svh"
module but_timer
  import but_pkg::*;
(
  input logic CLOCK_I,
  input logic RST_B_I,
  input logic AWVALID_I,
  output logic AWREADY_O,
  input but_addr_t AWADDR_I,
  input logic WVALID_I,
  output logic WREADY_O,
  input but_word_t WDATA_I,
  input logic [3:0] WSTRB_I,
  output logic BVALID_O,
  input logic BREADY_I,
  output logic [1:0] BRESP_O,
  input logic ARVALID_I,
  output logic ARREADY_O,
  input but_addr_t ARADDR_I,
  output logic RVALID_O,
  input logic RREADY_I,
  output but_word_t RDATA_O,
  output logic [1:0] RRESP_O,
  output logic TRIGGER_OUT_O,
  output logic IRQ_O,
  output logic DMA_REQ_O
);
  // Control bits
  logic counter_run_enable_r, counter_run_enable_nxt;
  logic update_inhibit_r, update_inhibit_nxt;
  logic update_source_select_r, update_source_select_nxt;
  logic one_shot_mode_r, one_shot_mode_nxt;
  logic reload_buffer_enable_r, reload_buffer_enable_nxt;
  logic [2:0] mmc_r, mmc_nxt;
  logic update_irq_enable_r, update_irq_enable_nxt;
  logic update_dma_enable_r, update_dma_enable_nxt;

  // Data registers
  but_cnt_t count_field_r, count_field_nxt;
  but_cnt_t prescale_field_r, prescale_field_nxt;
  but_cnt_t reload_field_r, reload_field_nxt;
  but_cnt_t reload_shadow_r, reload_shadow_nxt;

  // Status and outputs
  logic update_flag_r, update_flag_nxt;
  logic trigger_r, trigger_nxt;
  logic irq_r, irq_nxt;
  logic dma_r, dma_nxt;

  // Bus side
  logic wr_en;
  but_addr_t wr_addr;
  but_word_t wr_data;
  but_word_t rd_data;
  logic wr_err, rd_err;
  logic wr_control_zero, wr_control_one, wr_irq_dma_enable, wr_event_flags;
  logic wr_software_event, wr_count_value, wr_prescale_divisor, wr_reload_limit;

  // Events
  logic tick;
  logic force_update;
  logic overflow;
  logic update_event;
  logic update_qual;
  logic start_event;
  but_cnt_t reload_active;

  function automatic logic is_mapped(input but_addr_t addr);
    logic hit;
    hit = 1'b0;
    if (addr == `BUT_OFS_CTL0) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_CTL1) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_IE) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_FLG) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_SWE) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_CNT) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_PRESCALE) begin
      hit = 1'b1;
    end else if (addr == `BUT_OFS_CAR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  but_axil_slave u_bus (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .awaddr_i(AWADDR_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .bresp_o(BRESP_O),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_err_i(wr_err),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  assign wr_err = !is_mapped(wr_addr);
  assign rd_err = !is_mapped(ARADDR_I);

  // Write selects decoded once; a refused write selects nothing
  always_comb begin
    wr_control_zero = 1'b0;
    wr_control_one = 1'b0;
    wr_irq_dma_enable = 1'b0;
    wr_event_flags = 1'b0;
    wr_software_event = 1'b0;
    wr_count_value = 1'b0;
    wr_prescale_divisor = 1'b0;
    wr_reload_limit = 1'b0;
    if (wr_en) begin
      if (wr_addr == `BUT_OFS_CTL0) begin
        wr_control_zero = 1'b1;
      end else if (wr_addr == `BUT_OFS_CTL1) begin
        wr_control_one = 1'b1;
      end else if (wr_addr == `BUT_OFS_IE) begin
        wr_irq_dma_enable = 1'b1;
      end else if (wr_addr == `BUT_OFS_FLG) begin
        wr_event_flags = 1'b1;
      end else if (wr_addr == `BUT_OFS_SWE) begin
        wr_software_event = 1'b1;
      end else if (wr_addr == `BUT_OFS_CNT) begin
        wr_count_value = 1'b1;
      end else if (wr_addr == `BUT_OFS_PRESCALE) begin
        wr_prescale_divisor = 1'b1;
      end else if (wr_addr == `BUT_OFS_CAR) begin
        wr_reload_limit = 1'b1;
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_data = 32'h00000000;
    if (ARADDR_I == `BUT_OFS_CTL0) begin
      rd_data[`BUT_CTL0_RUN] = counter_run_enable_r;
      rd_data[`BUT_CTL0_INHIBIT] = update_inhibit_r;
      rd_data[`BUT_CTL0_SOURCE] = update_source_select_r;
      rd_data[`BUT_CTL0_ONE_SHOT] = one_shot_mode_r;
      rd_data[`BUT_CTL0_RELOAD_BUF] = reload_buffer_enable_r;
    end else if (ARADDR_I == `BUT_OFS_CTL1) begin
      rd_data[`BUT_CTL1_MMC_HI:`BUT_CTL1_MMC_LO] = mmc_r;
    end else if (ARADDR_I == `BUT_OFS_IE) begin
      rd_data[`BUT_IE_IRQ_EN] = update_irq_enable_r;
      rd_data[`BUT_IE_DMA_EN] = update_dma_enable_r;
    end else if (ARADDR_I == `BUT_OFS_FLG) begin
      rd_data[`BUT_FLG_UPDATE] = update_flag_r;
    end else if (ARADDR_I == `BUT_OFS_CNT) begin
      rd_data[15:0] = count_field_r;
    end else if (ARADDR_I == `BUT_OFS_PRESCALE) begin
      rd_data[15:0] = prescale_field_r;
    end else if (ARADDR_I == `BUT_OFS_CAR) begin
      rd_data[15:0] = reload_field_r;
    end
  end

  // Force-update is a pulse; nothing stores it, so it always reads zero
  assign force_update = wr_software_event && wr_data[`BUT_SWE_FUP];

  but_prescaler u_prescale (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .run_i(counter_run_enable_r),
    .clear_i(force_update),
    .load_i(update_event),
    .value_i(prescale_field_r),
    .tick_o(tick)
  );

  assign reload_active = reload_buffer_enable_r ? reload_shadow_r : reload_field_r;

  // A count write in the same cycle takes precedence over a tick
  assign overflow = tick && !force_update && !wr_count_value && (count_field_r == reload_active);
  assign update_event = (overflow || force_update) && !update_inhibit_r;
  // Update source select keeps forced updates off the flag and DMA
  assign update_qual = update_event && (!update_source_select_r || overflow);
  assign start_event = wr_control_zero && wr_data[`BUT_CTL0_RUN] && !counter_run_enable_r;

  // Control registers
  always_comb begin
    counter_run_enable_nxt = counter_run_enable_r;
    update_inhibit_nxt = update_inhibit_r;
    update_source_select_nxt = update_source_select_r;
    one_shot_mode_nxt = one_shot_mode_r;
    reload_buffer_enable_nxt = reload_buffer_enable_r;
    mmc_nxt = mmc_r;
    update_irq_enable_nxt = update_irq_enable_r;
    update_dma_enable_nxt = update_dma_enable_r;
    if (wr_control_zero) begin
      counter_run_enable_nxt = wr_data[`BUT_CTL0_RUN];
      update_inhibit_nxt = wr_data[`BUT_CTL0_INHIBIT];
      update_source_select_nxt = wr_data[`BUT_CTL0_SOURCE];
      one_shot_mode_nxt = wr_data[`BUT_CTL0_ONE_SHOT];
      reload_buffer_enable_nxt = wr_data[`BUT_CTL0_RELOAD_BUF];
    end
    if (wr_control_one) begin
      mmc_nxt = wr_data[`BUT_CTL1_MMC_HI:`BUT_CTL1_MMC_LO];
    end
    if (wr_irq_dma_enable) begin
      update_irq_enable_nxt = wr_data[`BUT_IE_IRQ_EN];
      update_dma_enable_nxt = wr_data[`BUT_IE_DMA_EN];
    end
    // Hardware stop wins over a simultaneous software write
    if (one_shot_mode_r && update_event) begin
      counter_run_enable_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      counter_run_enable_r <= `BUT_RST_BIT;
      update_inhibit_r <= `BUT_RST_BIT;
      update_source_select_r <= `BUT_RST_BIT;
      one_shot_mode_r <= `BUT_RST_BIT;
      reload_buffer_enable_r <= `BUT_RST_BIT;
      mmc_r <= `BUT_RST_MMC;
      update_irq_enable_r <= `BUT_RST_BIT;
      update_dma_enable_r <= `BUT_RST_BIT;
    end else begin
      counter_run_enable_r <= counter_run_enable_nxt;
      update_inhibit_r <= update_inhibit_nxt;
      update_source_select_r <= update_source_select_nxt;
      one_shot_mode_r <= one_shot_mode_nxt;
      reload_buffer_enable_r <= reload_buffer_enable_nxt;
      mmc_r <= mmc_nxt;
      update_irq_enable_r <= update_irq_enable_nxt;
      update_dma_enable_r <= update_dma_enable_nxt;
    end
  end

  // Counter and data registers
  always_comb begin
    count_field_nxt = count_field_r;
    prescale_field_nxt = prescale_field_r;
    reload_field_nxt = reload_field_r;
    reload_shadow_nxt = reload_shadow_r;
    if (wr_prescale_divisor) begin
      prescale_field_nxt = wr_data[15:0];
    end
    if (wr_reload_limit) begin
      reload_field_nxt = wr_data[15:0];
    end
    if (force_update) begin
      count_field_nxt = `BUT_RST_CNT;
    end else if (wr_count_value) begin
      count_field_nxt = wr_data[15:0];
    end else if (overflow) begin
      count_field_nxt = `BUT_RST_CNT;
    end else if (tick) begin
      count_field_nxt = count_field_r + 16'h0001;
    end
    // Shadow copy takes the limit in force before this cycle's write
    if (update_event) begin
      reload_shadow_nxt = reload_field_r;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      count_field_r <= `BUT_RST_CNT;
      prescale_field_r <= `BUT_RST_CNT;
      reload_field_r <= `BUT_RST_CNT;
      reload_shadow_r <= `BUT_RST_CNT;
    end else begin
      count_field_r <= count_field_nxt;
      prescale_field_r <= prescale_field_nxt;
      reload_field_r <= reload_field_nxt;
      reload_shadow_r <= reload_shadow_nxt;
    end
  end

  // Flag, interrupt level and output pulses
  always_comb begin
    update_flag_nxt = update_flag_r;
    if (wr_event_flags && !wr_data[`BUT_FLG_UPDATE]) begin
      update_flag_nxt = 1'b0;
    end
    // Set after clear so a coincident event is not lost
    if (update_qual) begin
      update_flag_nxt = 1'b1;
    end
    irq_nxt = update_flag_nxt && update_irq_enable_nxt;
    dma_nxt = update_qual && update_dma_enable_r;
    case (mmc_r)
      BUT_MMC_RESET: begin
        trigger_nxt = force_update;
      end
      BUT_MMC_START: begin
        trigger_nxt = start_event;
      end
      BUT_MMC_UPDATE: begin
        trigger_nxt = update_event;
      end
      default: begin
        trigger_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      update_flag_r <= `BUT_RST_BIT;
      irq_r <= `BUT_RST_BIT;
      dma_r <= `BUT_RST_BIT;
      trigger_r <= `BUT_RST_BIT;
    end else begin
      update_flag_r <= update_flag_nxt;
      irq_r <= irq_nxt;
      dma_r <= dma_nxt;
      trigger_r <= trigger_nxt;
    end
  end

  assign IRQ_O = irq_r;
  assign DMA_REQ_O = dma_r;
  assign TRIGGER_OUT_O = trigger_r;
endmodule : but_timer

// file: verif/but_timer_asserts.sv
// Concurrent checks on the basic timer top-level ports
`timescale 1ns/1ps
module but_timer_asserts
  import but_pkg::*;
(
  input logic CLOCK_I,
  input logic RST_B_I,
  input logic AWVALID_I,
  input logic AWREADY_O,
  input but_addr_t AWADDR_I,
  input logic WVALID_I,
  input logic WREADY_O,
  input but_word_t WDATA_I,
  input logic [3:0] WSTRB_I,
  input logic BVALID_O,
  input logic [1:0] BRESP_O,
  input logic ARVALID_I,
  input logic ARREADY_O,
  input but_addr_t ARADDR_I,
  input logic RVALID_O,
  input logic RREADY_I,
  input but_word_t RDATA_O,
  input logic [1:0] RRESP_O,
  input logic IRQ_O,
  input logic DMA_REQ_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  // Both halves taken together while no response is pending
  sequence s_wr_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O && !BVALID_O;
  endsequence
  sequence s_rd_take;
    ARVALID_I && ARREADY_O;
  endsequence

  a_reset_state: assert property (disable iff (1'b0) !RST_B_I |=>
    AWREADY_O && ARREADY_O && !BVALID_O && !RVALID_O && !IRQ_O && !DMA_REQ_O)
    else $error("outputs not idle in reset");
  a_wr_answer: assert property (s_wr_take |=> !AWREADY_O && !WREADY_O ##1 BVALID_O)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> RVALID_O && !ARREADY_O)
    else $error("read response late");
  a_rd_release: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read data held too long");
  a_strobe_err: assert property (s_wr_take ##0 (WSTRB_I != 4'hf) |-> ##2 BVALID_O && BRESP_O == 2'h2)
    else $error("partial write not refused");
  a_bad_read: assert property (s_rd_take ##0 (ARADDR_I == 12'h018) |=> RRESP_O == 2'h2 && RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  a_event_zero: assert property (s_rd_take ##0 (ARADDR_I == 12'h014) |=> RDATA_O == 32'h0)
    else $error("event register reads nonzero");
  a_irq_masked: assert property (s_wr_take ##0 (AWADDR_I == 12'h00c && !WDATA_I[0] && WSTRB_I == 4'hf)
    |-> ##4 !IRQ_O)
    else $error("interrupt not masked");
endmodule : but_timer_asserts

bind but_timer but_timer_asserts i_chk (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .WDATA_I(WDATA_I),
  .WSTRB_I(WSTRB_I), .BVALID_O(BVALID_O), .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
  .ARADDR_I(ARADDR_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
  .IRQ_O(IRQ_O), .DMA_REQ_O(DMA_REQ_O));

// file: verif/but_timer_tb.sv
// Self-checking bench for the basic timer
`timescale 1ns/1ps
module but_timer_tb
  import but_pkg::*;
;
  typedef struct {but_addr_t a; but_word_t w; but_word_t e; logic [1:0] r;} but_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  but_addr_t awaddr = '0, araddr = '0;
  but_word_t wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, trig, irq, dma;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0, checked = 0, cyc = 0, t_last = 0, gap = 0, n_dma = 0, n_trig = 0;
  // Address, write data, readback, response
  but_row_t rows [9] = '{'{12'h004, 32'h20, 32'h20, 2'h0}, '{12'h00c, 32'h100, 32'h100, 2'h0},
    '{12'h028, 32'h3, 32'h3, 2'h0}, '{12'h02c, 32'h5, 32'h5, 2'h0}, '{12'h024, 32'h4, 32'h4, 2'h0},
    '{12'h014, 32'h0, 32'h0, 2'h0}, '{12'h010, 32'h0, 32'h0, 2'h0}, '{12'h000, 32'h80, 32'h80, 2'h0},
    '{12'h018, 32'h1, 32'h0, 2'h2}};

  but_timer i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .AWADDR_I(awaddr), .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .ARADDR_I(araddr), .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
    .TRIGGER_OUT_O(trig), .IRQ_O(irq), .DMA_REQ_O(dma));

  always #20 clk = ~clk;

  // Pulse counters; gap is the cycle distance between request pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma === 1'b1) begin
      n_dma <= n_dma + 1;
      gap <= cyc - t_last;
      t_last <= cyc;
    end
    if (trig === 1'b1) n_trig <= n_trig + 1;
  end

  task automatic conclude();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input but_word_t seen, input but_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 400) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      conclude();
    end
  endtask : tmo

  // Leading edge keeps a release and the next request out of one time step
  task automatic wr(input but_addr_t a, input but_word_t d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 400);
    bready <= 1'b0;
    tmo(n);
    chk(32'(bresp), 32'(er));
  endtask : wr

  task automatic rchk(input but_addr_t a, input logic [1:0] er, input but_word_t e);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 400);
    rready <= 1'b0;
    tmo(n);
    chk(32'(rresp), 32'(er));
    chk(rdata, e);
  endtask : rchk

  task automatic wait_dma();
    int n, k;
    n = 0;
    k = n_dma;
    while (n_dma == k && n < 400) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask : wait_dma

  initial begin
    int k;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rchk(rows[i].a, rows[i].r, 32'h0);
      wr(rows[i].a, rows[i].w, 4'hf, rows[i].r);
      rchk(rows[i].a, rows[i].r, rows[i].e);
    end
    wr(12'h02c, 32'h9, 4'h3, 2'h2);
    rchk(12'h02c, 2'h0, 32'h5);
    wr(12'h014, 32'h1, 4'hf, 2'h0);
    rchk(12'h024, 2'h0, 32'h0);
    rchk(12'h010, 2'h0, 32'h1);
    chk(32'(n_dma), 32'h1);
    chk(32'(n_trig), 32'h1);
    wr(12'h010, 32'h1, 4'hf, 2'h0);
    rchk(12'h010, 2'h0, 32'h1);
    // Flag is up here, so only the mask can hold the line low
    chk(32'(irq), 32'h0);
    wr(12'h010, 32'h0, 4'hf, 2'h0);
    rchk(12'h010, 2'h0, 32'h0);
    wr(12'h000, 32'h81, 4'hf, 2'h0);
    wait_dma();
    wait_dma();
    chk(32'(gap), 32'h18);
    // Buffered limit and prescale wait one full old period
    wr(12'h028, 32'h1, 4'hf, 2'h0);
    wr(12'h02c, 32'h2, 4'hf, 2'h0);
    wait_dma();
    chk(32'(gap), 32'h18);
    wait_dma();
    chk(32'(gap), 32'h6);
    chk(32'(n_trig), 32'(n_dma));
    wr(12'h00c, 32'h101, 4'hf, 2'h0);
    wait_dma();
    @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(12'h00c, 32'h100, 4'hf, 2'h0);
    wr(12'h000, 32'h83, 4'hf, 2'h0);
    wr(12'h010, 32'h0, 4'hf, 2'h0);
    k = n_dma;
    repeat (40) @(posedge clk);
    chk(32'(n_dma), 32'(k));
    wr(12'h004, 32'h0, 4'hf, 2'h0);
    k = n_trig;
    wr(12'h014, 32'h1, 4'hf, 2'h0);
    rchk(12'h010, 2'h0, 32'h0);
    chk(32'(n_trig), 32'(k + 1));
    // Source select keeps a forced update off the flag and the request line
    wr(12'h000, 32'h84, 4'hf, 2'h0);
    k = n_dma;
    wr(12'h014, 32'h1, 4'hf, 2'h0);
    rchk(12'h010, 2'h0, 32'h0);
    chk(32'(n_dma), 32'(k));
    wr(12'h000, 32'h80, 4'hf, 2'h0);
    wr(12'h024, 32'h1, 4'hf, 2'h0);
    repeat (10) @(posedge clk);
    rchk(12'h024, 2'h0, 32'h1);
    wr(12'h004, 32'h10, 4'hf, 2'h0);
    k = n_trig;
    wr(12'h000, 32'h89, 4'hf, 2'h0);
    wait_dma();
    rchk(12'h000, 2'h0, 32'h88);
    rchk(12'h024, 2'h0, 32'h0);
    chk(32'(n_trig), 32'(k + 1));
    // Reset after the one-shot stop must bring the mode and limit registers back to zero
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rchk(12'h004, 2'h0, 32'h0);
    rchk(12'h02c, 2'h0, 32'h0);
    conclude();
  end
endmodule : but_timer_tb
